// ==== rcp_decoder_model.sv ====
// Behavioural receiver decoder that listens to the encoder's carrier line.
// Assumes carrier_on is driven from logic on the same clk.
module rcp_decoder_model #(
  parameter int unsigned TIMEOUT_CYC = 30,
  parameter int unsigned PULSE_CYC   = 10
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic carrier_on,
  output logic      servo1,
  output logic      servo2,
  output logic      first_onoff_output,
  output logic      second_onoff_output
);
  logic [1:0]  sy_ff;
  logic [2:0]  cnt_ff;
  logic [1:0]  lat_ff;
  logic        synced_ff;
  int unsigned tmr_ff;
  int unsigned os_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sy_ff     <= 2'h3;
      cnt_ff    <= 3'h0;
      lat_ff    <= 2'h0;
      synced_ff <= 1'b0;
      tmr_ff    <= 0;
      os_ff     <= 0;
    end else begin
      // Lag is equal on both edges, so slot widths survive
      sy_ff  <= {sy_ff[0], carrier_on};
      tmr_ff <= sy_ff[0] ? tmr_ff + 1 : 0;
      if (sy_ff[1] && !sy_ff[0]) cnt_ff <= cnt_ff + 3'h1;
      if (tmr_ff == TIMEOUT_CYC) os_ff <= 2 * PULSE_CYC;
      else if (os_ff != 0) os_ff <= os_ff - 1;
      if (os_ff > PULSE_CYC) lat_ff <= cnt_ff[1:0];
      if (os_ff == 1) begin
        cnt_ff    <= 3'h0;
        synced_ff <= 1'b1;
      end
    end
  end
  assign servo1              = synced_ff && cnt_ff == 3'h1;
  assign servo2              = synced_ff && cnt_ff == 3'h2;
  assign first_onoff_output  = lat_ff[0];
  assign second_onoff_output = lat_ff[1];
endmodule : rcp_decoder_model

// ==== rcp_frame_encoder.sv ====
// Transmitter-side frame encoder: drives the carrier-present line of a
// radio-control receiver/decoder with carrier-interrupt pulse frames.
// Assumes channel widths come from logic on clk; on/off inputs are pins.
// Assumes the receiver's sync timeout lies between the longest channel and the sync.
module rcp_frame_encoder #(
  parameter int unsigned CYCLES_PER_US = rcp_pkg::CYCLES_PER_US,
  parameter int unsigned DROPOUT_CYC   = rcp_pkg::DROPOUT_CYC,
  parameter int unsigned FIXED_CH_CYC  = rcp_pkg::FIXED_CH_CYC,
  parameter int unsigned SYNC_CYC      = rcp_pkg::SYNC_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [rcp_pkg::US_W-1:0] ch1_interval_us,
  input  wire logic [rcp_pkg::US_W-1:0] ch2_interval_us,
  input  wire logic                     first_onoff_input,
  input  wire logic                     second_onoff_input,
  output logic                          carrier_on,
  output logic                          frame_start
);

  localparam logic [rcp_pkg::TIMER_W-1:0] DROP_LOAD  = rcp_pkg::TIMER_W'(DROPOUT_CYC);
  localparam logic [rcp_pkg::TIMER_W-1:0] FIXED_LOAD = rcp_pkg::TIMER_W'(FIXED_CH_CYC);
  localparam logic [rcp_pkg::TIMER_W-1:0] SYNC_LOAD  = rcp_pkg::TIMER_W'(SYNC_CYC);
  localparam logic [rcp_pkg::US_W-1:0]    CH_MIN     = rcp_pkg::US_W'(rcp_pkg::CH_MIN_US);
  localparam logic [rcp_pkg::US_W-1:0]    CH_MAX     = rcp_pkg::US_W'(rcp_pkg::CH_MAX_US);
  localparam int unsigned                 N_ANALOG   = int'(rcp_pkg::ANALOG_CHANNELS);

  // Two-flop synchronisers for the on/off switch pins; the two bits may settle a
  // cycle apart, which is harmless because they are only read at the end of a sync
  logic [1:0] onoff_meta_ff;
  logic [1:0] onoff_sync_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      onoff_meta_ff <= 2'h0;
      onoff_sync_ff <= 2'h0;
    end else begin
      onoff_meta_ff <= {second_onoff_input, first_onoff_input};
      onoff_sync_ff <= onoff_meta_ff;
    end
  end

  // Clamp a channel width into the legal range and scale it to cycles; the
  // ceiling keeps every channel well below the receiver's sync timeout
  function automatic logic [rcp_pkg::TIMER_W-1:0] to_cycles(input logic [rcp_pkg::US_W-1:0] us);
    logic [rcp_pkg::US_W-1:0] lim;
    lim = us;
    if (lim < CH_MIN) begin
      lim = CH_MIN;
    end else if (lim > CH_MAX) begin
      lim = CH_MAX;
    end
    return rcp_pkg::TIMER_W'(32'(lim) * CYCLES_PER_US);
  endfunction : to_cycles

  // Both analog widths share one clamp and scale; the result is only taken at the
  // end of a sync, so a width that moves mid-frame waits for the next frame
  logic [rcp_pkg::US_W-1:0]    ch_us [N_ANALOG];
  logic [rcp_pkg::TIMER_W-1:0] ch_load [N_ANALOG];

  assign ch_us[0] = ch1_interval_us;
  assign ch_us[1] = ch2_interval_us;

  for (genvar g = 0; g < N_ANALOG; g++) begin : g_analog
    assign ch_load[g] = to_cycles(ch_us[g]);
  end

  // Fixed channels carry the on/off pair as a count: one, plus the two-bit code
  // read as a binary number, so no setting ever sends zero fixed channels
  logic [rcp_pkg::CHAN_W-1:0] fixed_count;

  assign fixed_count = (rcp_pkg::BASE_CHANNELS - rcp_pkg::ANALOG_CHANNELS) + {1'b0, onoff_sync_ff};

  // Frame sequencer state
  rcp_pkg::rcp_state_t              state_ff;
  rcp_pkg::rcp_state_t              nxt_state;
  logic [rcp_pkg::CHAN_W-1:0]       chan_ff;
  logic [rcp_pkg::CHAN_W-1:0]       nxt_chan;
  logic [rcp_pkg::CHAN_W-1:0]       total_ff;
  logic [rcp_pkg::CHAN_W-1:0]       nxt_total;
  logic [rcp_pkg::TIMER_W-1:0]      ch1_cyc_ff;
  logic [rcp_pkg::TIMER_W-1:0]      nxt_ch1_cyc;
  logic [rcp_pkg::TIMER_W-1:0]      ch2_cyc_ff;
  logic [rcp_pkg::TIMER_W-1:0]      nxt_ch2_cyc;
  logic                             carrier_ff;
  logic                             nxt_carrier;
  logic                             start_ff;
  logic                             nxt_start;
  logic                             timer_load;
  logic [rcp_pkg::TIMER_W-1:0]      timer_value;
  logic                             timer_expired;

  // One shared timer: exactly one interval is running at any time
  rcp_interval_timer u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (timer_load),
    .load_value (timer_value),
    .expired    (timer_expired)
  );

  // Each state hands the timer its next length in the cycle the current one
  // expires, so no idle cycle slips in between intervals
  always_comb begin
    nxt_state   = state_ff;
    nxt_chan    = chan_ff;
    nxt_total   = total_ff;
    nxt_ch1_cyc = ch1_cyc_ff;
    nxt_ch2_cyc = ch2_cyc_ff;
    nxt_start   = 1'b0;
    timer_load  = 1'b0;
    timer_value = SYNC_LOAD;
    unique case (state_ff)
      rcp_pkg::RCP_ST_START: begin
        // Open with a sync so the receiver aligns before the first frame
        timer_load  = 1'b1;
        timer_value = SYNC_LOAD;
        nxt_state   = rcp_pkg::RCP_ST_SYNC;
      end
      rcp_pkg::RCP_ST_SYNC: begin
        if (timer_expired) begin
          // Inputs are sampled once per frame so a frame is self-consistent
          nxt_ch1_cyc = ch_load[0];
          nxt_ch2_cyc = ch_load[1];
          nxt_total   = rcp_pkg::ANALOG_CHANNELS + fixed_count;
          nxt_chan    = 3'h0;
          nxt_start   = 1'b1;
          timer_load  = 1'b1;
          timer_value = DROP_LOAD;
          nxt_state   = rcp_pkg::RCP_ST_DROP;
        end
      end
      rcp_pkg::RCP_ST_DROP: begin
        if (timer_expired) begin
          // The dropout before slot k opens channel k: two analog widths, then fixed ones
          timer_load = 1'b1;
          if (chan_ff == 3'h0) begin
            timer_value = ch1_cyc_ff;
          end else if (chan_ff == 3'h1) begin
            timer_value = ch2_cyc_ff;
          end else begin
            timer_value = FIXED_LOAD;
          end
          nxt_state = rcp_pkg::RCP_ST_CHAN;
        end
      end
      rcp_pkg::RCP_ST_CHAN: begin
        if (timer_expired) begin
          timer_load  = 1'b1;
          timer_value = DROP_LOAD;
          // One closing dropout after the last channel gives channels plus one edges
          if (chan_ff == total_ff - 3'h1) begin
            nxt_state = rcp_pkg::RCP_ST_DROP_LAST;
          end else begin
            nxt_chan  = chan_ff + 3'h1;
            nxt_state = rcp_pkg::RCP_ST_DROP;
          end
        end
      end
      rcp_pkg::RCP_ST_DROP_LAST: begin
        // The closing dropout gives the receiver its last count edge before the sync
        if (timer_expired) begin
          timer_load  = 1'b1;
          timer_value = SYNC_LOAD;
          nxt_state   = rcp_pkg::RCP_ST_SYNC;
        end
      end
      default: begin
        nxt_state = rcp_pkg::RCP_ST_START;
      end
    endcase
    // Carrier follows the state being entered, so it changes on the same edge
    nxt_carrier = 1'b1;
    if ((nxt_state == rcp_pkg::RCP_ST_DROP) || (nxt_state == rcp_pkg::RCP_ST_DROP_LAST)) begin
      nxt_carrier = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff   <= rcp_pkg::RCP_ST_START;
      chan_ff    <= 3'h0;
      total_ff   <= rcp_pkg::BASE_CHANNELS;
      ch1_cyc_ff <= 20'h00001;
      ch2_cyc_ff <= 20'h00001;
      // Carrier rests high through reset so the receiver sees no stray dropout
      carrier_ff <= 1'b1;
      start_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      chan_ff    <= nxt_chan;
      total_ff   <= nxt_total;
      ch1_cyc_ff <= nxt_ch1_cyc;
      ch2_cyc_ff <= nxt_ch2_cyc;
      carrier_ff <= nxt_carrier;
      start_ff   <= nxt_start;
    end
  end

  assign carrier_on  = carrier_ff;
  assign frame_start = start_ff;

endmodule : rcp_frame_encoder

// ==== rcp_frame_encoder_checker.sv ====
// Timing and pulse-count checks on the encoder's carrier line.
// Assumes it is bound to rcp_frame_encoder and sees only its ports.
module rcp_frame_encoder_checker #(
  parameter int unsigned DROPOUT_CYC  = 10,
  parameter int unsigned FIXED_CH_CYC = 10,
  parameter int unsigned SYNC_CYC     = 60
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic first_onoff_input,
  input wire logic second_onoff_input,
  input wire logic carrier_on,
  input wire logic frame_start
);
  logic        car_ff, seen_ff, nxt_seen;
  logic [19:0] lo_ff, hi_ff, nxt_lo, nxt_hi;
  logic [2:0]  falls_ff, nxt_falls;
  logic [1:0]  code_ff, nxt_code;
  // The encoder reads its pins through two flops, one edge before frame_start
  logic [1:0]  pin_d1_ff, pin_d2_ff, pin_d3_ff;
  always_comb begin
    nxt_lo    = carrier_on ? 20'h0 : lo_ff + 20'h1;
    nxt_hi    = carrier_on ? hi_ff + 20'h1 : 20'h0;
    nxt_falls = frame_start ? 3'h1 : falls_ff + {2'h0, car_ff & ~carrier_on};
    nxt_code  = frame_start ? pin_d3_ff : code_ff;
    nxt_seen  = seen_ff | frame_start;
  end
  always_ff @(posedge clk) begin
    car_ff   <= rst_n ? carrier_on : 1'b1;
    lo_ff    <= rst_n ? nxt_lo : 20'h0;
    hi_ff    <= rst_n ? nxt_hi : 20'h0;
    falls_ff <= rst_n ? nxt_falls : 3'h0;
    code_ff  <= rst_n ? nxt_code : 2'h0;
    seen_ff  <= rst_n ? nxt_seen : 1'b0;
    pin_d1_ff <= rst_n ? {second_onoff_input, first_onoff_input} : 2'h0;
    pin_d2_ff <= rst_n ? pin_d1_ff : 2'h0;
    pin_d3_ff <= rst_n ? pin_d2_ff : 2'h0;
  end
  sequence drop_end_s;
    !carrier_on ##1 carrier_on;
  endsequence
  sequence sync_end_s;
    carrier_on ##1 frame_start;
  endsequence
  drop_len_a: assert property (@(posedge clk) disable iff (!rst_n) drop_end_s |-> lo_ff == DROPOUT_CYC)
    else $error("dropout length differs");
  sync_len_a: assert property (@(posedge clk) disable iff (!rst_n) sync_end_s |-> hi_ff >= SYNC_CYC)
    else $error("sync interval too short");
  chan_short_a: assert property (@(posedge clk) disable iff (!rst_n)
    (car_ff && !carrier_on && !frame_start) |-> hi_ff < SYNC_CYC)
    else $error("channel interval reaches sync length");
  start_edge_a: assert property (@(posedge clk) disable iff (!rst_n) frame_start |-> $fell(carrier_on) ##1 !frame_start)
    else $error("frame start not on a single dropout edge");
  pulse_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_start && seen_ff) |-> falls_ff == 3'h4 + {1'b0, code_ff})
    else $error("dropout count does not match on/off code");
  fixed_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (car_ff && !carrier_on && !frame_start && falls_ff >= 3'h3) |-> hi_ff == FIXED_CH_CYC)
    else $error("fixed channel length differs");
endmodule : rcp_frame_encoder_checker

// ==== rcp_interval_timer.sv ====
// Down counter that times one frame interval.
// Assumes the loader asserts load in the cycle it wants a new interval to start.
module rcp_interval_timer (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        load,
  input  wire logic [rcp_pkg::TIMER_W-1:0] load_value,
  output logic                             expired
);

  logic [rcp_pkg::TIMER_W-1:0] count_ff;
  logic [rcp_pkg::TIMER_W-1:0] nxt_count;

  // Interval of N cycles: count reaches one N-1 edges after the load, and the
  // loader moves on at the edge after that
  always_comb begin
    nxt_count = count_ff;
    if (load) begin
      nxt_count = load_value;
    end else if (count_ff != '0) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign expired = (count_ff == {{(rcp_pkg::TIMER_W-1){1'b0}}, 1'b1});

endmodule : rcp_interval_timer

// ==== rcp_pkg.sv ====
// Shared constants of the carrier-interrupt frame encoder.
// Assumes a 100 MHz system clock; all frame times are in microseconds.
package rcp_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned NS_PER_US       = 1000;
  localparam int unsigned CYCLES_PER_US   = NS_PER_US / CLK_PERIOD_NS;

  // Frame timing in microseconds
  localparam int unsigned DROPOUT_US      = 500;   // dropout_interval
  localparam int unsigned FIXED_CH_US     = 500;   // carrier-on part of a fixed-width channel
  localparam int unsigned SYNC_TIMEOUT_US = 3500;  // receiver sync timer
  localparam int unsigned SYNC_US         = 5000;  // sync_interval sent, longer than the timeout
  localparam int unsigned CH_MIN_US       = 1;
  localparam int unsigned CH_MAX_US       = 2000;  // longest channel_interval, well below the timeout

  // Derived cycle counts (exact multiples, so no rounding is needed)
  localparam int unsigned DROPOUT_CYC     = DROPOUT_US * CYCLES_PER_US;
  localparam int unsigned FIXED_CH_CYC    = FIXED_CH_US * CYCLES_PER_US;
  localparam int unsigned SYNC_CYC        = SYNC_US * CYCLES_PER_US;

  localparam int unsigned TIMER_W         = 20;
  localparam int unsigned US_W            = 12;
  localparam int unsigned CHAN_W          = 3;

  // Channels per frame: two analog plus one to four fixed ones
  localparam logic [CHAN_W-1:0] ANALOG_CHANNELS = 3'h2;
  localparam logic [CHAN_W-1:0] BASE_CHANNELS   = 3'h3;

  typedef enum logic [2:0] {
    RCP_ST_START     = 3'h0,
    RCP_ST_SYNC      = 3'h1,
    RCP_ST_DROP      = 3'h2,
    RCP_ST_CHAN      = 3'h3,
    RCP_ST_DROP_LAST = 3'h4
  } rcp_state_t;

endpackage : rcp_pkg

// ==== tb_rcp_frame_encoder.sv ====
// Testbench of the frame encoder against a receiver decoder model.
// Assumes shortened timing parameters; widths stay below the sync timeout.
module tb_rcp_frame_encoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CPU = 2;
  localparam int unsigned DROP = 10;
  logic        clk = 1'b0, rst_n = 1'b0, first_in = 1'b0, second_in = 1'b0;
  logic [11:0] ch1 = 12'h000, ch2 = 12'h005;
  logic        carrier_on, frame_start, servo1, servo2, out_a, out_b;
  int          fail_count = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  rcp_frame_encoder #(.CYCLES_PER_US(CPU), .DROPOUT_CYC(DROP), .FIXED_CH_CYC(10), .SYNC_CYC(60)) uut (
    .clk(clk), .rst_n(rst_n), .ch1_interval_us(ch1), .ch2_interval_us(ch2), .first_onoff_input(first_in),
    .second_onoff_input(second_in), .carrier_on(carrier_on), .frame_start(frame_start));
  rcp_decoder_model #(.TIMEOUT_CYC(30), .PULSE_CYC(10)) rx (.clk(clk), .rst_n(rst_n), .carrier_on(carrier_on),
    .servo1(servo1), .servo2(servo2), .first_onoff_output(out_a), .second_onoff_output(out_b));
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_start(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (frame_start !== 1'b1 && k < 1000);
    if (frame_start !== 1'b1) begin
      chk({15'h0, frame_start}, 16'h0001);
      results();
    end
  endtask : wait_start
  task automatic t_reset();
    chk({carrier_on, frame_start}, 16'h0002);
    wait_start(n);
    chk(16'(n > 60), 16'h0001);
  endtask : t_reset
  // Width 0 is clamped to 1 us, so slot 1 is one dropout plus CPU cycles
  task automatic t_servo();
    int c1, c2, k;
    wait_start(n);
    wait_start(n);
    c1 = 0;
    c2 = 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      c1 += int'(servo1 === 1'b1);
      c2 += int'(servo2 === 1'b1);
    end while (frame_start !== 1'b1 && k < 1000);
    if (frame_start !== 1'b1) begin
      chk({15'h0, frame_start}, 16'h0001);
      results();
    end
    chk(16'(c1), 16'(DROP + CPU));
    chk(16'(c2), 16'(DROP + 5 * CPU));
  endtask : t_servo
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      first_in = c[0];
      second_in = c[1];
      wait_start(n);
      wait_start(n);
      chk({14'h0, out_b, out_a}, 16'(c));
    end
  endtask : t_codes
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_servo();
    t_codes();
    results();
  end
endmodule : tb_rcp_frame_encoder
bind rcp_frame_encoder rcp_frame_encoder_checker #(.DROPOUT_CYC(DROPOUT_CYC), .FIXED_CH_CYC(FIXED_CH_CYC),
  .SYNC_CYC(SYNC_CYC)) chk_i (
  .clk(clk), .rst_n(rst_n), .first_onoff_input(first_onoff_input), .second_onoff_input(second_onoff_input),
  .carrier_on(carrier_on), .frame_start(frame_start));
